/* hw/kdr_pkg.sv */
// kdr_pkg: shared constants and types of the key debounce and ready block
package kdr_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int DIGIT_TIME_US = 70;
    localparam int DIGIT_CYCLES_DEF = (DIGIT_TIME_US * 1000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // scan geometry
    // ------------------------------------------------------------
    localparam int N_LINES = 4;
    localparam int DIG_W = 4;
    localparam logic [3:0] FIRST_DIGIT = 4'h0;
    localparam logic [3:0] LAST_DIGIT = 4'h8;
    localparam logic [3:0] SHORT_DIGIT_DEF = 4'h8;

    // ------------------------------------------------------------
    // debounce lengths in word times
    // ------------------------------------------------------------
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] CLOSE_WORDS_NORM = 5'h08;
    localparam logic [4:0] REL_WORDS_NORM = 5'h08;
    localparam logic [4:0] WORDS_SHORT = 5'h04;
    localparam logic [4:0] CLOSE_WORDS_ASYM = 5'h09;
    localparam logic [4:0] REL_WORDS_ASYM = 5'h10;

    // ------------------------------------------------------------
    // segment codes
    // ------------------------------------------------------------
    localparam logic [7:0] SEG_BLANK = 8'h00;
    localparam logic [7:0] SEG_DP = 8'h80;
    localparam logic [3:0] VAL_ZERO = 4'h0;
    localparam logic [3:0] VAL_MAX = 4'h9;

    typedef enum logic [1:0] {ST_IDLE, ST_CLOSE, ST_BUSY, ST_REL} kdr_fsm_t;

    typedef struct packed {
        logic valid;
        logic [3:0] digit;
        logic [3:0] lines;
    } kdr_key_t;

    // upper nibble gates the selected digit onto the key lines
    typedef struct packed {
        logic [3:0] gate;
        logic [3:0] sel;
    } kdr_ctl_t;

    typedef struct packed {
        logic full;
        kdr_ctl_t ctl;
    } kdr_cmd_t;

    function automatic logic [6:0] kdr_seg_of(input logic [3:0] v);
        case (v)
            4'h0: kdr_seg_of = 7'h3f;
            4'h1: kdr_seg_of = 7'h06;
            4'h2: kdr_seg_of = 7'h5b;
            4'h3: kdr_seg_of = 7'h4f;
            4'h4: kdr_seg_of = 7'h66;
            4'h5: kdr_seg_of = 7'h6d;
            4'h6: kdr_seg_of = 7'h7d;
            4'h7: kdr_seg_of = 7'h07;
            4'h8: kdr_seg_of = 7'h7f;
            4'h9: kdr_seg_of = 7'h6f;
            default: kdr_seg_of = 7'h00;
        endcase
    endfunction

endpackage

/* hw/kdr_seg.sv */
// kdr_seg: segment decode of the scanned digit with zero suppression
`timescale 1ns/10ps
module kdr_seg (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic tick_i,
    input wire logic [3:0] digit_i,
    input wire logic [3:0] val_i,
    input wire logic dp_i,
    input wire logic left_just_i,
    output logic [7:0] seg_o
);
    import kdr_pkg::*;

    typedef struct packed {
        logic lead_zero;
        logic [3:0] last_nz;
        logic [3:0] last_nz_acc;
    } kdr_seg_st_t;

    kdr_seg_st_t st;
    kdr_seg_st_t next_st;
    logic is_zero;
    logic blank;

    // ------------------------------------------------------------
    // suppression
    // ------------------------------------------------------------
    // digit 0 is the leftmost; the last digit (right-justified) or the first (left-justified) is never blanked so zero shows
    // trailing blanking uses the previous word's last nonzero digit, which is
    // cheap; leading blanking needs the current word, except digit 0, which uses the previous word's all-zero flag
    always_comb begin
        next_st = st;
        is_zero = (val_i == VAL_ZERO) && !dp_i;
        if (left_just_i) begin
            blank = is_zero && (digit_i > st.last_nz) && (digit_i != FIRST_DIGIT);
        end else begin
            blank = is_zero && st.lead_zero && (digit_i != LAST_DIGIT);
        end
        if (val_i > VAL_MAX) begin
            seg_o = dp_i ? SEG_DP : SEG_BLANK;
        end else if (blank) begin
            seg_o = SEG_BLANK;
        end else begin
            seg_o = {dp_i, kdr_seg_of(val_i)};
        end
        if (tick_i) begin
            if (digit_i == FIRST_DIGIT) begin
                next_st.lead_zero = is_zero;
                next_st.last_nz_acc = FIRST_DIGIT;
            end else begin
                next_st.lead_zero = st.lead_zero && is_zero;
            end
            if (!is_zero) begin
                next_st.last_nz_acc = digit_i;
            end
            if (digit_i == LAST_DIGIT) begin
                next_st.last_nz = is_zero ? st.last_nz_acc : digit_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '{lead_zero: 1'b1, last_nz: LAST_DIGIT, last_nz_acc: FIRST_DIGIT};
        end else begin
            st <= next_st;
        end
    end

    a_lead_blank: assert property (@(posedge clk_i) disable iff (reset_i)
        (!left_just_i && st.lead_zero && val_i == VAL_ZERO && !dp_i
         && digit_i != LAST_DIGIT) |-> seg_o == SEG_BLANK)
        else $error("leading zero not suppressed");

endmodule

/* hw/kdr_top.sv */
// kdr_top: key debounce, ready status and host command path
// Function
// - key closure starts the debounce timer
// - disturbance during debounce clears timer to zero
// - accept key only after clean debounce interval
// - releases debounced the same restartable way
// - ready high while idle
// - ready falls when key accepted
// - ready rises after function done and release
// - suppress trailing or leading zeros by justification
// - asymmetric variant: 9 words close, 16 release
// - strobe during set digit halves debounce (symmetric variant only)
// - control bytes 00-08 select digit readout
// - control word: select low, gate high, ready clears
`timescale 1ns/10ps
module kdr_top #(
    parameter int DIGIT_CYCLES = kdr_pkg::DIGIT_CYCLES_DEF,
    parameter bit ASYMMETRIC = 1'b0,
    parameter logic [3:0] SHORT_DIGIT = kdr_pkg::SHORT_DIGIT_DEF
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [3:0] key_i,
    input wire logic short_strobe_i,
    input wire logic func_done_i,
    input wire logic [3:0] digit_val_i,
    input wire logic digit_dp_i,
    input wire logic left_just_i,
    input wire logic cmd_valid_i,
    input wire kdr_pkg::kdr_ctl_t cmd_i,
    output logic cmd_ready_o,
    output logic ready_o,
    output logic [8:0] digit_o,
    output logic key_accept_o,
    output kdr_pkg::kdr_key_t key_code_o,
    output logic [7:0] seg_o,
    output logic readout_valid_o,
    output logic [7:0] readout_o
);
    import kdr_pkg::*;

    localparam int DIV_W = $clog2(DIGIT_CYCLES);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIGIT_CYCLES - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = '0;

    typedef struct packed {
        logic [3:0] k_meta;
        logic [3:0] k_sync;
        logic s_meta;
        logic s_sync;
        logic [DIV_W-1:0] div;
        logic [3:0] digit;
        kdr_fsm_t fsm;
        kdr_key_t cur;
        kdr_key_t prev;
        logic short_seen;
        logic short_word;
        logic [4:0] count;
        logic ready;
        logic accept;
        kdr_key_t code;
        kdr_cmd_t cmd;
        logic [7:0] seg;
        logic rd_valid;
        logic [7:0] rd;
    } kdr_top_st_t;

    kdr_top_st_t st;
    kdr_top_st_t next_st;
    logic tick;
    logic word_end;
    logic [3:0] lines;
    kdr_key_t word_code;
    logic stable;
    logic [4:0] close_thr;
    logic [4:0] rel_thr;
    logic [7:0] seg_now;

    kdr_seg u_seg (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .tick_i(tick),
        .digit_i(st.digit),
        .val_i(digit_val_i),
        .dp_i(digit_dp_i),
        .left_just_i(left_just_i),
        .seg_o(seg_now)
    );

    // ------------------------------------------------------------
    // debounce length per variant
    // ------------------------------------------------------------
    function automatic logic [4:0] thr_of(input logic closing, input logic short_w);
        if (ASYMMETRIC) begin
            thr_of = closing ? CLOSE_WORDS_ASYM : REL_WORDS_ASYM;
        end else if (short_w) begin
            thr_of = WORDS_SHORT;
        end else begin
            thr_of = closing ? CLOSE_WORDS_NORM : REL_WORDS_NORM;
        end
    endfunction

    // ------------------------------------------------------------
    // scan, debounce and ready
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.k_meta = key_i;
        next_st.k_sync = st.k_meta;
        next_st.s_meta = short_strobe_i;
        next_st.s_sync = st.s_meta;
        next_st.accept = 1'b0;
        next_st.rd_valid = 1'b0;
        tick = (st.div == DIV_LAST);
        word_end = tick && (st.digit == LAST_DIGIT);
        // emulated closure gated onto the key lines
        lines = st.k_sync;
        if (st.cmd.full && st.cmd.ctl.gate != 4'h0 && st.cmd.ctl.sel == st.digit) begin
            lines = st.k_sync | st.cmd.ctl.gate;
        end
        word_code = st.cur;
        if (tick && !st.cur.valid && lines != 4'h0) begin
            word_code = '{valid: 1'b1, digit: st.digit, lines: lines};
        end
        stable = (word_code == st.prev);
        close_thr = thr_of(1'b1, st.short_word);
        rel_thr = thr_of(1'b0, st.short_word);
        next_st.div = tick ? DIV_ZERO : st.div + 1'b1;
        if (tick) begin
            next_st.seg = seg_now;
            next_st.cur = word_code;
            next_st.digit = (st.digit == LAST_DIGIT) ? FIRST_DIGIT : st.digit + 1'b1;
            // strobe in the chosen digit shortens the next count
            if (st.digit == SHORT_DIGIT && st.s_sync) begin
                next_st.short_seen = 1'b1;
            end
            if (st.cmd.full && st.cmd.ctl.gate == 4'h0 && st.cmd.ctl.sel == st.digit) begin
                next_st.rd = seg_now;
                next_st.rd_valid = 1'b1;
                next_st.cmd.full = 1'b0;
            end
        end
        if (st.cmd.full && st.cmd.ctl.gate == 4'h0 && st.cmd.ctl.sel > LAST_DIGIT) begin
            next_st.cmd.full = 1'b0;
        end
        // commands only taken while ready is high
        if (cmd_valid_i && st.ready && !st.cmd.full) begin
            next_st.cmd = '{full: 1'b1, ctl: cmd_i};
        end
        if (word_end) begin
            next_st.prev = word_code;
            next_st.cur = '0;
            next_st.short_seen = 1'b0;
            next_st.short_word = st.short_seen || (st.digit == SHORT_DIGIT && st.s_sync);
        end
        case (st.fsm)
            ST_IDLE: begin
                next_st.ready = 1'b1;
                if (word_end && word_code.valid) begin
                    next_st.fsm = ST_CLOSE;
                    next_st.count = CNT_ONE;
                end
            end
            ST_CLOSE: begin
                if (word_end) begin
                    if (!word_code.valid) begin
                        next_st.fsm = ST_IDLE;
                        next_st.count = CNT_ZERO;
                    end else if (!stable) begin
                        next_st.count = CNT_ZERO;
                    end else if (st.count + 1'b1 >= close_thr) begin
                        next_st.fsm = ST_BUSY;
                        next_st.ready = 1'b0;
                        next_st.accept = 1'b1;
                        next_st.code = word_code;
                        next_st.cmd.full = 1'b0;
                        next_st.count = CNT_ZERO;
                    end else begin
                        next_st.count = st.count + 1'b1;
                    end
                end
            end
            ST_BUSY: begin
                if (func_done_i) begin
                    next_st.fsm = ST_REL;
                    next_st.count = CNT_ZERO;
                end
            end
            ST_REL: begin
                if (word_end) begin
                    if (word_code.valid || !stable) begin
                        // release timer restarts on any closure
                        next_st.count = CNT_ZERO;
                    end else if (st.count + 1'b1 >= rel_thr) begin
                        next_st.fsm = ST_IDLE;
                        next_st.ready = 1'b1;
                        next_st.count = CNT_ZERO;
                    end else begin
                        next_st.count = st.count + 1'b1;
                    end
                end
            end
            default: begin
                next_st.fsm = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
            st.fsm <= ST_IDLE;
            st.ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // segment data is good at the rising edge of ready: no settle delay is added
    assign cmd_ready_o = st.ready && !st.cmd.full;
    assign ready_o = st.ready;
    assign key_accept_o = st.accept;
    assign key_code_o = st.code;
    assign seg_o = st.seg;
    assign readout_valid_o = st.rd_valid;
    assign readout_o = st.rd;

    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_dig
            assign digit_o[gi] = (st.digit == DIG_W'(gi));
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_idle_ready: assert property (@(posedge clk_i) disable iff (reset_i)
        st.fsm == ST_IDLE |-> ready_o)
        else $error("ready low while idle");

    a_close_starts: assert property (@(posedge clk_i) disable iff (reset_i)
        (st.fsm == ST_IDLE && word_end && word_code.valid) |=> st.fsm == ST_CLOSE)
        else $error("closure did not start debounce");

    a_disturb_clear: assert property (@(posedge clk_i) disable iff (reset_i)
        (st.fsm == ST_CLOSE && word_end && word_code.valid && !stable)
        |=> st.count == CNT_ZERO && st.fsm == ST_CLOSE)
        else $error("disturbance did not clear timer");

    a_accept_count: assert property (@(posedge clk_i) disable iff (reset_i)
        key_accept_o |-> $past(st.count) + 5'h01 == $past(close_thr))
        else $error("key accepted before full interval");

    a_ready_fall: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(ready_o) |-> key_accept_o && !st.cmd.full)
        else $error("ready fell without acceptance");

    a_ready_rise: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(ready_o) |-> $past(st.fsm) == ST_REL && $past(st.count) + 5'h01 == $past(rel_thr))
        else $error("ready rose before release debounced");

    a_rel_restart: assert property (@(posedge clk_i) disable iff (reset_i)
        (st.fsm == ST_REL && word_end && word_code.valid) |=> st.count == CNT_ZERO)
        else $error("release timer not restarted");

    a_word_count: assert property (@(posedge clk_i) disable iff (reset_i)
        (!word_end && st.fsm != ST_BUSY) |=> $stable(st.count))
        else $error("timer moved outside word end");

    a_busy_low: assert property (@(posedge clk_i) disable iff (reset_i)
        st.fsm == ST_BUSY |-> !ready_o ##1 (st.fsm != ST_IDLE))
        else $error("ready high while processing");

endmodule

/* sim/kdr_keypad.sv */
// kdr_keypad: key matrix model that closes one contact on its scanned digit
`timescale 1ns/10ps
module kdr_keypad (
    input wire logic clk_i,
    input wire logic [8:0] digit_i,
    input wire logic down_i,
    input wire logic noisy_i,
    input wire logic [3:0] dig_i,
    input wire logic [3:0] lines_i,
    output logic [3:0] key_o
);
    logic flip = 1'b0;
    // digit 0 is strobed out of reset; starting there avoids a false edge
    logic [8:0] last = 9'h001;

    // flip once a word, at the start of digit 0
    always @(posedge clk_i) begin
        last <= digit_i;
        if (digit_i[0] && !last[0]) begin
            flip <= ~flip;
        end
    end

    // a matrix only returns a level while its digit line is strobed;
    // noise swaps between two nonzero codes so no two successive words agree
    always_comb begin
        key_o = 4'h0;
        if (down_i && digit_i[dig_i]) begin
            key_o = (noisy_i && flip) ? ~lines_i : lines_i;
        end
    end
endmodule

/* sim/kdr_top_test.sv */
// kdr_top_test: self-checking bench of key debounce, ready and readout paths
`timescale 1ns/10ps
module kdr_top_test;
    import kdr_pkg::*;
    localparam int DC = 4;
    localparam int WORD = 9 * DC;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] key_i;
    logic short_strobe_i = 1'b0;
    logic func_done_i = 1'b0;
    logic [3:0] digit_val_i = 4'h1;
    logic digit_dp_i = 1'b0;
    logic left_just_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    kdr_ctl_t cmd_i = 8'h00;
    logic cmd_ready_o, ready_o, key_accept_o, readout_valid_o;
    logic [8:0] digit_o;
    kdr_key_t key_code_o;
    logic [7:0] seg_o;
    logic [7:0] readout_o;
    logic down = 1'b0;
    logic noisy = 1'b0;
    logic [3:0] kdig = 4'h0;
    logic [3:0] klines = 4'h1;
    logic [8:0] exp_key[$];
    logic [7:0] exp_rd[$];
    logic [6:0] seg_tbl[10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
        7'h7f, 7'h6f};
    int seed = 32'h35e3297d;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int t;

    kdr_top #(.DIGIT_CYCLES(DC)) dut (.clk_i(clk_i), .reset_i(reset_i), .key_i(key_i),
        .short_strobe_i(short_strobe_i), .func_done_i(func_done_i),
        .digit_val_i(digit_val_i), .digit_dp_i(digit_dp_i), .left_just_i(left_just_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
        .ready_o(ready_o), .digit_o(digit_o), .key_accept_o(key_accept_o),
        .key_code_o(key_code_o), .seg_o(seg_o), .readout_valid_o(readout_valid_o),
        .readout_o(readout_o));
    kdr_keypad pad (.clk_i(clk_i), .digit_i(digit_o), .down_i(down), .noisy_i(noisy),
        .dig_i(kdig), .lines_i(klines), .key_o(key_i));

    always #4 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task chk_key(input logic [8:0] exp);
        chk("key code", exp, key_code_o);
    endtask

    task chk_rd(input logic [7:0] exp);
        chk("readout", exp, readout_o);
    endtask

    task results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // every result pulse must match the oldest note; an unnoted pulse is an error
    always @(posedge clk_i) begin
        #2;
        if (key_accept_o === 1'b1) begin
            chk("ready at accept", 32'h0, ready_o);
            if (exp_key.size() == 0) chk("unexpected accept", 32'h0, 32'h1);
            else chk_key(exp_key.pop_front());
        end
        if (readout_valid_o === 1'b1) begin
            if (exp_rd.size() == 0) chk("unexpected readout", 32'h0, 32'h1);
            else chk_rd(exp_rd.pop_front());
        end
    end

    // the whole run needs about 5000 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task wait_hi(input int which, input int lim, output int n);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit && n < lim) begin
            @(posedge clk_i);
            #2;
            n++;
            if (which == 0) hit = key_accept_o === 1'b1;
            else if (which == 1) hit = ready_o === 1'b1;
            else hit = readout_valid_o === 1'b1;
        end
        if (!hit) chk("wait bound", 32'h1, 32'h0);
        @(posedge clk_i);
        #1;
    endtask

    task send(input logic [3:0] g, input logic [3:0] s);
        int n;
        logic rdy;
        n = 0;
        cmd_i = {g, s};
        cmd_valid_i = 1'b1;
        // ready is first read between edges, where it has settled; each later read falls at the edge itself
        do begin
            rdy = cmd_ready_o;
            @(posedge clk_i);
            n++;
        end while (rdy !== 1'b1 && n < 2000);
        if (rdy !== 1'b1) chk("cmd bound", 32'h1, 32'h0);
        #1;
        cmd_valid_i = 1'b0;
    endtask

    task read_dig(input logic [3:0] s, input logic [7:0] exp);
        exp_rd.push_back(exp);
        send(4'h0, s);
        wait_hi(2, 11 * WORD, t);
    endtask

    task finish_key(input int min_words);
        func_done_i = 1'b1;
        @(posedge clk_i);
        #1;
        func_done_i = 1'b0;
        repeat (5 * WORD) @(posedge clk_i);
        #1;
        chk("ready before release", 32'h0, ready_o);
        down = 1'b0;
        wait_hi(1, 20 * WORD, t);
        chk("release debounce", 32'h1, t >= min_words * WORD);
    endtask

    task press(input logic short);
        kdig = 4'($unsigned($random(seed)) % 9);
        klines = 4'h1 << ($random(seed) & 3);
        short_strobe_i = short;
        exp_key.push_back({1'b1, kdig, klines});
        chk("ready before press", 32'h1, ready_o);
        down = 1'b1;
        wait_hi(0, 14 * WORD, t);
        if (short) chk("short debounce", 32'h1, t >= 3 * WORD && t <= 6 * WORD);
        else chk("close debounce", 32'h1, t >= 7 * WORD && t <= 10 * WORD);
        finish_key(short ? 3 : 7);
        short_strobe_i = 1'b0;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        #1;
        chk("ready in reset", 32'h1, ready_o);
        reset_i = 1'b0;
        @(posedge clk_i);
        #1;
        chk("cmd ready idle", 32'h1, cmd_ready_o);
        press(1'b0);
        press(1'b1);
        kdig = 4'h3;
        klines = 4'h2;
        noisy = 1'b1;
        down = 1'b1;
        repeat (20 * WORD) @(posedge clk_i);
        #1;
        chk("ready under noise", 32'h1, ready_o);
        noisy = 1'b0;
        exp_key.push_back({1'b1, kdig, klines});
        wait_hi(0, 14 * WORD, t);
        chk("clean interval", 32'h1, t >= 7 * WORD);
        finish_key(7);
        exp_key.push_back({1'b1, 4'h5, 4'h2});
        send(4'h2, 4'h5);
        chk("cmd register full", 32'h0, cmd_ready_o);
        wait_hi(0, 14 * WORD, t);
        finish_key(3);
        chk("cmd ready again", 32'h1, cmd_ready_o);
        digit_val_i = 4'(1 + $unsigned($random(seed)) % 9);
        digit_dp_i = 1'($random(seed));
        left_just_i = 1'($random(seed));
        repeat (2 * WORD) @(posedge clk_i);
        #1;
        chk("segments", {digit_dp_i, seg_tbl[digit_val_i]}, seg_o);
        for (int s = 0; s < 9; s++) begin
            read_dig(4'(s), {digit_dp_i, seg_tbl[digit_val_i]});
        end
        digit_val_i = 4'h0;
        digit_dp_i = 1'b0;
        left_just_i = 1'b0;
        repeat (2 * WORD) @(posedge clk_i);
        #1;
        read_dig(4'h0, 8'h00);
        read_dig(4'h8, 8'h3f);
        left_just_i = 1'b1;
        repeat (2 * WORD) @(posedge clk_i);
        #1;
        read_dig(4'h0, 8'h3f);
        read_dig(4'h4, 8'h00);
        send(4'h0, 4'h9);
        repeat (12 * WORD) @(posedge clk_i);
        #1;
        chk("cmd ready after drop", 32'h1, cmd_ready_o);
        results();
    end
endmodule
